// ### dv/host_xfer_model.sv
module host_xfer_model (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic start_in,
    input wire logic [1:0] ep_in,
    input wire logic slow_in,
    input wire logic resp_valid_in,
    input wire usb_ep_desc_pkg::resp_kind_t resp_kind_in,
    output logic req_out,
    output logic [1:0] req_ep_out,
    output logic done_out,
    output logic [1:0] done_ep_out,
    output logic busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import usb_ep_desc_pkg::*;
    logic [1:0] ep;
    initial begin
        {req_out, done_out, busy_out} = 3'h0;
        {req_ep_out, done_ep_out} = 4'h0;
        forever begin
            @(posedge clk_in);
            if (start_in === 1'h1 && rst_b_in === 1'h1) begin
                ep = ep_in;
                busy_out <= 1'h1;
                req_out <= 1'h1;
                req_ep_out <= ep;
                @(posedge clk_in);
                req_out <= 1'h0;
                req_ep_out <= ~ep;
                @(posedge clk_in);
                // only a delivered packet is acknowledged
                if (resp_valid_in === 1'h1 && resp_kind_in === RESP_DATA) begin
                    repeat (slow_in ? 4 : 0) @(posedge clk_in);
                    done_out <= 1'h1;
                    done_ep_out <= ep;
                    @(posedge clk_in);
                    done_out <= 1'h0;
                    done_ep_out <= ~ep;
                end
                busy_out <= 1'h0;
            end
        end
    end
endmodule

// ### dv/test_usb_endpoint_descriptor_regs.sv
module test_usb_endpoint_descriptor_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import usb_ep_desc_pkg::*;
    logic clk_in, rst_b_in, wr_en_in, rd_en_in, stall_set_in, out_req_in;
    logic [7:0] addr_in, wr_data_in, rd_data_out;
    logic in_req_in, in_resp_valid_out, in_resp_data1_out, in_done_in;
    logic out_size_valid_out, irq_out, go, go_slow, busy;
    logic [1:0] in_req_ep_in, in_done_ep_in, stall_set_ep_in;
    logic [1:0] out_req_ep_in, go_ep;
    resp_kind_t in_resp_kind_out;
    logic [10:0] in_resp_addr_out;
    logic [6:0] in_resp_count_out, out_size_out;
    logic [7:0] sz[1:3], cfg[1:3], xb[1:3], yb[1:3], xc[1:3];
    logic [2:0] st, mk, fws;
    int mismatches, checked, seed, v;
    initial begin
        clk_in = 1'h0;
        forever #50 clk_in = ~clk_in;
    end
    usb_endpoint_descriptor_regs dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .in_req_in(in_req_in),
        .in_req_ep_in(in_req_ep_in), .in_resp_valid_out(in_resp_valid_out),
        .in_resp_kind_out(in_resp_kind_out), .in_done_in(in_done_in),
        .in_resp_addr_out(in_resp_addr_out), .in_done_ep_in(in_done_ep_in),
        .in_resp_count_out(in_resp_count_out), .stall_set_in(stall_set_in),
        .in_resp_data1_out(in_resp_data1_out), .out_req_in(out_req_in),
        .stall_set_ep_in(stall_set_ep_in), .out_req_ep_in(out_req_ep_in),
        .out_size_valid_out(out_size_valid_out), .out_size_out(out_size_out),
        .irq_out(irq_out));
    host_xfer_model host (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .start_in(go), .ep_in(go_ep), .slow_in(go_slow),
        .resp_valid_in(in_resp_valid_out), .resp_kind_in(in_resp_kind_out),
        .req_out(in_req_in), .req_ep_out(in_req_ep_in), .done_out(in_done_in),
        .done_ep_out(in_done_ep_in), .busy_out(busy));
    // ----
    // checking and bus tasks
    // ----
    task automatic results;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_port(input logic [10:0] got, input logic [10:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t port got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] exp_rd(input logic [3:0] e,
                                          input logic [3:0] r);
        if (e == 4'h0 && r < 4'h2) return {5'h00, (r == 4'h0) ? st : mk};
        if (e == 4'h0 || e > 4'h3) return 8'h00;
        case (r)
            4'h0: return sz[e];
            4'h1: return cfg[e];
            4'h2: return xb[e];
            4'h3: return xc[e];
            4'h4: return yb[e];
            default: return 8'h00;
        endcase
    endfunction
    function automatic resp_kind_t exp_kind(input logic [1:0] e);
        if (!cfg[e][7]) return RESP_NAK;
        if (cfg[e][3]) return RESP_STALL;
        return xc[e][7] ? RESP_NAK : RESP_DATA;
    endfunction
    task automatic wr(input logic [3:0] e, input logic [3:0] r,
                      input logic [7:0] d);
        @(posedge clk_in);
        wr_en_in <= 1'h1;
        addr_in <= {e, r};
        wr_data_in <= d;
        @(posedge clk_in);
        wr_en_in <= 1'h0;
        if (e == 4'h0 && r == 4'h1) begin
            mk = d[2:0];
        end else if (e > 4'h0 && e < 4'h4) begin
            case (r)
                4'h0: sz[e] = d & SIZE_RW_MASK;
                4'h1: begin
                    cfg[e] = d & CFG_RW_MASK;
                    fws[e-1] = d[3];
                end
                4'h2: xb[e] = d;
                4'h3: xc[e] = d;
                4'h4: yb[e] = d;
                default: ;
            endcase
        end
    endtask
    task automatic rd(input logic [3:0] e, input logic [3:0] r);
        logic [7:0] x;
        x = exp_rd(e, r);
        @(posedge clk_in);
        rd_en_in <= 1'h1;
        addr_in <= {e, r};
        @(posedge clk_in);
        rd_en_in <= 1'h0;
        #1;
        chk_reg(rd_data_out, x);
        if (e == 4'h0 && r == 4'h0) st = 3'h0;
    endtask
    task automatic osz(input logic [1:0] e);
        @(posedge clk_in);
        out_req_in <= 1'h1;
        out_req_ep_in <= e;
        @(posedge clk_in);
        out_req_in <= 1'h0;
        #1;
        chk_port(11'(out_size_out), 11'(sz[e][6:0]));
        chk_port(11'(out_size_valid_out), 11'(cfg[e][7]));
    endtask
    task automatic hstall(input logic [1:0] e);
        @(posedge clk_in);
        stall_set_in <= 1'h1;
        stall_set_ep_in <= e;
        @(posedge clk_in);
        stall_set_in <= 1'h0;
        cfg[e][3] = 1'h1;
        fws[e-1] = 1'h0;
    endtask
    task automatic xfer(input logic [1:0] e, input logic s);
        resp_kind_t k;
        logic [10:0] a;
        int n;
        k = exp_kind(e);
        a = {(cfg[e][4] & cfg[e][5]) ? yb[e] : xb[e], 3'h0};
        @(posedge clk_in);
        go <= 1'h1;
        go_ep <= e;
        go_slow <= s;
        @(posedge clk_in);
        go <= 1'h0;
        n = 0;
        #1;
        while (busy !== 1'h0 && n < 20) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk_port(11'(in_resp_kind_out), 11'(k));
        if (k == RESP_DATA) begin
            chk_port(in_resp_addr_out, a);
            chk_port(11'(in_resp_count_out), 11'(xc[e][6:0]));
            chk_port(11'(in_resp_data1_out), 11'(cfg[e][5]));
            cfg[e][5] = ~cfg[e][5];
            xc[e][7] = 1'h1;
            st[e-1] = st[e-1] | cfg[e][2];
        end
        if (k == RESP_STALL && fws[e-1]) cfg[e][3] = 1'h0;
        repeat (2) @(posedge clk_in);
        #1;
        chk_port(11'(irq_out), 11'(|(st & mk)));
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        results();
    end
    initial begin
        seed = 21004;
        {wr_en_in, rd_en_in, stall_set_in, out_req_in, go, go_slow} = 6'h00;
        {addr_in, wr_data_in, stall_set_ep_in, out_req_ep_in} = 20'h00000;
        go_ep = 2'h0;
        mismatches = 0;
        checked = 0;
        {st, mk, fws} = 9'h000;
        for (int i = 1; i < 4; i++) begin
            {sz[i], cfg[i], xb[i], yb[i]} = {SIZE_RST, CFG_RST, {2{BASE_RST}}};
            xc[i] = XCNT_RST;
        end
        rst_b_in = 1'h0;
        repeat (20) @(posedge clk_in);
        rst_b_in <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            for (int r = 0; r < 6; r++) rd(i[3:0], r[3:0]);
        end
        wr(4'h0, 4'hF, 8'hFF);
        rd(4'h0, 4'hF);
        wr(4'h0, 4'h1, 8'h07);
        wr(4'h1, 4'h2, 8'hFF);
        wr(4'h1, 4'h3, 8'h40);
        xfer(2'h1, 1'h0);
        wr(4'h1, 4'h1, 8'hA7);
        xfer(2'h1, 1'h1);
        xfer(2'h1, 1'h0);
        rd(4'h0, 4'h0);
        wr(4'h1, 4'h4, 8'h21);
        wr(4'h1, 4'h1, 8'hB0);
        wr(4'h1, 4'h3, 8'h00);
        xfer(2'h1, 1'h0);
        rd(4'h1, 4'h2);
        rd(4'h0, 4'h0);
        wr(4'h2, 4'h1, 8'h88);
        xfer(2'h2, 1'h0);
        rd(4'h2, 4'h1);
        wr(4'h3, 4'h1, 8'h80);
        hstall(2'h3);
        xfer(2'h3, 1'h0);
        xfer(2'h3, 1'h1);
        rd(4'h3, 4'h1);
        wr(4'h3, 4'h1, 8'h80);
        rd(4'h3, 4'h1);
        for (int rnd = 0; rnd < 6; rnd++) begin
            wr(4'h0, 4'h1, 8'($random(seed)));
            for (int i = 1; i < 4; i++) begin
                v = $random(seed);
                wr(i[3:0], 4'h0, {v[7], 7'(v[6:0] % 65)});
                wr(i[3:0], 4'h1, v[15:8] & 8'hB7);
                wr(i[3:0], 4'h2, v[23:16]);
                wr(i[3:0], 4'h3, {v[24], 7'(v[31:25] % 65)});
                wr(i[3:0], 4'h4, 8'($random(seed)));
                for (int r = 0; r < 6; r++) rd(i[3:0], r[3:0]);
                osz(i[1:0]);
                xfer(i[1:0], v[5]);
                rd(i[3:0], 4'h4);
            end
            rd(4'h0, 4'h0);
        end
        results();
    end
endmodule

// ### dv/usb_ep_desc_checker_sva.sv
module usb_ep_desc_checker (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] addr_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] rd_data_out,
    input wire logic in_req_in,
    input wire logic [1:0] in_req_ep_in,
    input wire logic in_resp_valid_out,
    input wire usb_ep_desc_pkg::resp_kind_t in_resp_kind_out,
    input wire logic [10:0] in_resp_addr_out,
    input wire logic [6:0] in_resp_count_out,
    input wire logic in_done_in,
    input wire logic out_req_in,
    input wire logic [1:0] out_req_ep_in,
    input wire logic out_size_valid_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import usb_ep_desc_pkg::*;
    // ----
    // request, register read, size lookup and interrupt checks
    // ----
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    wire logic req_ok = in_req_in && (in_req_ep_in != 2'h0);
    wire logic ep_rd = rd_en_in && (addr_in[7:4] inside {4'h1, 4'h2, 4'h3});
    wire logic data_ans = in_resp_valid_out && (in_resp_kind_out == RESP_DATA);
    resp_timing_a: assert property (req_ok |=> in_resp_valid_out)
        else $error("answer missing one cycle after request");
    resp_only_a: assert property (!req_ok |=> !in_resp_valid_out)
        else $error("answer without request");
    base_align_a: assert property (in_resp_valid_out |->
        in_resp_addr_out[2:0] == 3'h0)
        else $error("start address not 8-byte aligned");
    resp_hold_a: assert property (!in_resp_valid_out |->
        $stable(in_resp_kind_out) && $stable(in_resp_addr_out)
        && $stable(in_resp_count_out))
        else $error("answer fields changed between answers");
    count_max_a: assert property (data_ans |->
        in_resp_count_out <= MAX_LEN)
        else $error("count beyond 64 bytes");
    cfg_rsv_a: assert property (ep_rd && addr_in[3:0] == REG_IN_CFG
        |=> rd_data_out[1:0] == 2'h0)
        else $error("config reserved bits not zero");
    size_rsv_a: assert property (ep_rd && addr_in[3:0] == REG_OUT_SIZE
        |=> rd_data_out[7] == 1'h0)
        else $error("size reserved bit not zero");
    rd_idle_a: assert property (!rd_en_in |=> rd_data_out == 8'h00)
        else $error("read data outside read slot");
    irq_cause_a: assert property ($rose(irq_out) |->
        $past(in_done_in) || $past(wr_en_in, 2))
        else $error("interrupt rose without cause");
    out_valid_a: assert property (!(out_req_in && out_req_ep_in != 2'h0)
        |=> !out_size_valid_out)
        else $error("size valid without lookup");
    stall_c: cover property (in_resp_valid_out
        && in_resp_kind_out == RESP_STALL);
    data_c: cover property (data_ans);
    irq_c: cover property ($rose(irq_out));
    size_c: cover property (out_size_valid_out);
endmodule

bind usb_endpoint_descriptor_regs usb_ep_desc_checker u_chk (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
    .in_req_in(in_req_in), .in_req_ep_in(in_req_ep_in),
    .in_resp_valid_out(in_resp_valid_out),
    .in_resp_kind_out(in_resp_kind_out),
    .in_resp_addr_out(in_resp_addr_out),
    .in_resp_count_out(in_resp_count_out), .in_done_in(in_done_in),
    .out_req_in(out_req_in), .out_req_ep_in(out_req_ep_in),
    .out_size_valid_out(out_size_valid_out), .irq_out(irq_out)
);

// ### logic/buf_start_addr.sv
module buf_start_addr (
    input wire logic double_buffer_en_en_in,
    input wire logic data_toggle_bit_in,
    input wire logic [usb_ep_desc_pkg::BASE_W-1:0] x_base_in,
    input wire logic [usb_ep_desc_pkg::BASE_W-1:0] y_base_in,
    output logic [usb_ep_desc_pkg::BUF_ADDR_W-1:0] start_addr_out
);
    import usb_ep_desc_pkg::*;

    logic [BASE_W-1:0] base_sel;

    // y buffer only when double buffering and toggle is one
    assign base_sel = (double_buffer_en_en_in && data_toggle_bit_in) ?
                      y_base_in : x_base_in;
    assign start_addr_out = {base_sel, {ALIGN_BITS{1'b0}}};
endmodule

// ### logic/usb_endpoint_descriptor_regs.sv
module usb_endpoint_descriptor_regs (
    input wire logic clk_in,
    input wire logic rst_b_in,
    // register port
    input wire logic [usb_ep_desc_pkg::ADDR_W-1:0] addr_in,
    input wire logic [usb_ep_desc_pkg::DATA_W-1:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [usb_ep_desc_pkg::DATA_W-1:0] rd_data_out,
    // host IN request from the buffer manager
    input wire logic in_req_in,
    input wire logic [usb_ep_desc_pkg::EP_W-1:0] in_req_ep_in,
    output logic in_resp_valid_out,
    output usb_ep_desc_pkg::resp_kind_t in_resp_kind_out,
    output logic [usb_ep_desc_pkg::BUF_ADDR_W-1:0] in_resp_addr_out,
    output logic [usb_ep_desc_pkg::CNT_W-1:0] in_resp_count_out,
    output logic in_resp_data1_out,
    // completed IN transaction
    input wire logic in_done_in,
    input wire logic [usb_ep_desc_pkg::EP_W-1:0] in_done_ep_in,
    // stall raised by the buffer manager
    input wire logic stall_set_in,
    input wire logic [usb_ep_desc_pkg::EP_W-1:0] stall_set_ep_in,
    // out endpoint size lookup
    input wire logic out_req_in,
    input wire logic [usb_ep_desc_pkg::EP_W-1:0] out_req_ep_in,
    output logic out_size_valid_out,
    output logic [usb_ep_desc_pkg::CNT_W-1:0] out_size_out,
    // interrupt
    output logic irq_out
);
    import usb_ep_desc_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [DATA_W-1:0] size_r [1:NUM_EP];
    logic [DATA_W-1:0] cfg_r [1:NUM_EP];
    logic [DATA_W-1:0] xbase_r [1:NUM_EP];
    logic [DATA_W-1:0] xcnt_r [1:NUM_EP];
    logic [DATA_W-1:0] ybase_r [1:NUM_EP];
    logic [NUM_EP:1] fw_stall_r;
    logic [NUM_EP-1:0] irq_status_r;
    logic [NUM_EP-1:0] irq_status_nxt;
    logic [NUM_EP-1:0] irq_mask_r;
    logic [BUF_ADDR_W-1:0] start_addr [1:NUM_EP];

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [3:0] ep_sel;
    logic [3:0] reg_sel;
    logic status_rd;
    logic mask_wr;

    assign ep_sel = addr_in[ADDR_W-1:EP_SEL_LSB];
    assign reg_sel = addr_in[EP_SEL_LSB-1:0];
    assign status_rd = rd_en_in && (addr_in == IRQ_STATUS_OFS);
    assign mask_wr = wr_en_in && (addr_in == IRQ_MASK_OFS);

    // ------------------------------------------------------------
    // per-endpoint descriptor
    // ------------------------------------------------------------
    logic [NUM_EP:1] req_hit;
    logic [NUM_EP:1] done_hit;
    logic [NUM_EP:1] stall_hit;
    logic [NUM_EP:1] stall_served;
    logic [NUM_EP:1] ep_done_event;

    genvar e;
    generate
        for (e = 1; e <= NUM_EP; e++) begin : g_ep
            logic blk_wr;
            logic size_wr;
            logic cfg_wr;
            logic xbase_wr;
            logic xcnt_wr;
            logic ybase_wr;
            logic [DATA_W-1:0] cfg_nxt;
            logic [DATA_W-1:0] xcnt_nxt;

            assign blk_wr = wr_en_in && (ep_sel == 4'(e));
            assign size_wr = blk_wr && (reg_sel == REG_OUT_SIZE);
            assign cfg_wr = blk_wr && (reg_sel == REG_IN_CFG);
            assign xbase_wr = blk_wr && (reg_sel == REG_IN_XBASE);
            assign xcnt_wr = blk_wr && (reg_sel == REG_IN_XCNT);
            assign ybase_wr = blk_wr && (reg_sel == REG_IN_YBASE);

            // buffer manager touches only enabled endpoints
            assign req_hit[e] = in_req_in && (in_req_ep_in == EP_W'(e))
                                && cfg_r[e][CFG_ACCESS_EN_BIT];
            assign done_hit[e] = in_done_in
                                 && (in_done_ep_in == EP_W'(e))
                                 && cfg_r[e][CFG_ACCESS_EN_BIT];
            assign stall_hit[e] = stall_set_in
                                  && (stall_set_ep_in == EP_W'(e))
                                  && cfg_r[e][CFG_ACCESS_EN_BIT];
            assign stall_served[e] = req_hit[e]
                                     && cfg_r[e][CFG_STALL_BIT];
            assign ep_done_event[e] = done_hit[e]
                                      && cfg_r[e][CFG_IRQ_EN_BIT];

            // size: reserved top bit never stored
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    size_r[e] <= SIZE_RST;
                end else if (size_wr) begin
                    size_r[e] <= wr_data_in & SIZE_RW_MASK;
                end
            end

            // base registers: firmware is the only writer
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    xbase_r[e] <= BASE_RST;
                    ybase_r[e] <= BASE_RST;
                end else begin
                    if (xbase_wr) begin
                        xbase_r[e] <= wr_data_in;
                    end
                    if (ybase_wr) begin
                        ybase_r[e] <= wr_data_in;
                    end
                end
            end

            // config: firmware write first, hardware updates override
            always_comb begin
                cfg_nxt = cfg_r[e];
                if (cfg_wr) begin
                    cfg_nxt = wr_data_in & CFG_RW_MASK;
                end
                if (stall_served[e] && fw_stall_r[e]) begin
                    cfg_nxt[CFG_STALL_BIT] = 1'b0;
                end
                if (stall_hit[e]) begin
                    cfg_nxt[CFG_STALL_BIT] = 1'b1;
                end
                if (done_hit[e]) begin
                    cfg_nxt[CFG_TOGGLE_BIT] =
                        ~cfg_r[e][CFG_TOGGLE_BIT];
                end
            end

            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    cfg_r[e] <= CFG_RST;
                end else begin
                    cfg_r[e] <= cfg_nxt;
                end
            end

            // remembers that firmware, not hardware, raised the stall
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    fw_stall_r[e] <= 1'b0;
                end else if (cfg_wr) begin
                    fw_stall_r[e] <= wr_data_in[CFG_STALL_BIT];
                end else if (stall_served[e]) begin
                    fw_stall_r[e] <= 1'b0;
                end
            end

            // x count: buffer drained marks it empty again
            always_comb begin
                xcnt_nxt = xcnt_r[e];
                if (xcnt_wr) begin
                    xcnt_nxt = wr_data_in;
                end
                if (done_hit[e]) begin
                    xcnt_nxt[CNT_NAK_BIT] = 1'b1;
                end
            end

            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    xcnt_r[e] <= XCNT_RST;
                end else begin
                    xcnt_r[e] <= xcnt_nxt;
                end
            end

            buf_start_addr u_start (
                .double_buffer_en_en_in(cfg_r[e][CFG_DOUBLE_BUFFER_EN_BIT]),
                .data_toggle_bit_in(cfg_r[e][CFG_TOGGLE_BIT]),
                .x_base_in(xbase_r[e]),
                .y_base_in(ybase_r[e]),
                .start_addr_out(start_addr[e])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // IN answer
    // ------------------------------------------------------------
    logic req_ep_ok;
    logic [EP_W-1:0] rq;

    assign rq = in_req_ep_in;
    assign req_ep_ok = (rq != 2'h0);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            in_resp_valid_out <= 1'b0;
        end else begin
            in_resp_valid_out <= in_req_in && req_ep_ok;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            in_resp_kind_out <= RESP_NAK;
            in_resp_addr_out <= '0;
            in_resp_count_out <= '0;
            in_resp_data1_out <= 1'b0;
        end else if (in_req_in && req_ep_ok) begin
            in_resp_addr_out <= start_addr[rq];
            in_resp_count_out <= xcnt_r[rq][CNT_W-1:0];
            in_resp_data1_out <= cfg_r[rq][CFG_TOGGLE_BIT];
            if (!cfg_r[rq][CFG_ACCESS_EN_BIT]) begin
                in_resp_kind_out <= RESP_NAK;
            end else if (cfg_r[rq][CFG_STALL_BIT]) begin
                in_resp_kind_out <= RESP_STALL;
            end else if (xcnt_r[rq][CNT_NAK_BIT]) begin
                in_resp_kind_out <= RESP_NAK;
            end else begin
                in_resp_kind_out <= RESP_DATA;
            end
        end
    end

    // ------------------------------------------------------------
    // OUT size lookup
    // ------------------------------------------------------------
    logic [EP_W-1:0] oq;

    assign oq = out_req_ep_in;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            out_size_valid_out <= 1'b0;
            out_size_out <= '0;
        end else begin
            out_size_valid_out <= out_req_in && (oq != 2'h0)
                                  && cfg_r[oq][CFG_ACCESS_EN_BIT];
            if (out_req_in && (oq != 2'h0)) begin
                out_size_out <= size_r[oq][CNT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    // a completion in the clearing read's cycle stays set
    always_comb begin
        irq_status_nxt = status_rd ? '0 : irq_status_r;
        irq_status_nxt = irq_status_nxt | ep_done_event;
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_status_r <= IRQ_RST;
        end else begin
            irq_status_r <= irq_status_nxt;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_mask_r <= IRQ_RST;
        end else if (mask_wr) begin
            irq_mask_r <= wr_data_in[NUM_EP-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_status_nxt & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_mux;
    logic [EP_W-1:0] rd_ep;

    assign rd_ep = ep_sel[EP_W-1:0];

    always_comb begin
        rd_mux = '0;
        if (addr_in == IRQ_STATUS_OFS) begin
            rd_mux = {{(DATA_W-NUM_EP){1'b0}}, irq_status_r};
        end else if (addr_in == IRQ_MASK_OFS) begin
            rd_mux = {{(DATA_W-NUM_EP){1'b0}}, irq_mask_r};
        end else if (ep_sel >= 4'h1 && ep_sel <= 4'h3) begin
            unique case (reg_sel)
                REG_OUT_SIZE: rd_mux = size_r[rd_ep];
                REG_IN_CFG: rd_mux = cfg_r[rd_ep];
                REG_IN_XBASE: rd_mux = xbase_r[rd_ep];
                REG_IN_XCNT: rd_mux = xcnt_r[rd_ep];
                REG_IN_YBASE: rd_mux = ybase_r[rd_ep];
                default: rd_mux = '0;
            endcase
        end
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= rd_en_in ? rd_mux : '0;
        end
    end
endmodule

// ### logic/usb_ep_desc_pkg.sv
package usb_ep_desc_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_EP = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int EP_W = 2;
    localparam int CNT_W = 7;
    localparam int BASE_W = 8;
    localparam int ALIGN_BITS = 3;
    localparam int BUF_ADDR_W = 11;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h01;
    // endpoint n occupies the block whose upper nibble is n
    localparam int EP_SEL_LSB = 4;
    localparam logic [3:0] REG_OUT_SIZE = 4'h0;
    localparam logic [3:0] REG_IN_CFG = 4'h1;
    localparam logic [3:0] REG_IN_XBASE = 4'h2;
    localparam logic [3:0] REG_IN_XCNT = 4'h3;
    localparam logic [3:0] REG_IN_YBASE = 4'h4;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CFG_IRQ_EN_BIT = 2;
    localparam int CFG_STALL_BIT = 3;
    localparam int CFG_DOUBLE_BUFFER_EN_BIT = 4;
    localparam int CFG_TOGGLE_BIT = 5;
    localparam int CFG_ISO_BIT = 6;
    localparam int CFG_ACCESS_EN_BIT = 7;
    localparam int CNT_NAK_BIT = 7;
    localparam logic [DATA_W-1:0] CFG_RW_MASK = 8'hFC;
    localparam logic [DATA_W-1:0] SIZE_RW_MASK = 8'h7F;
    localparam logic [CNT_W-1:0] MAX_LEN = 7'h40;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] SIZE_RST = 8'h00;
    localparam logic [DATA_W-1:0] CFG_RST = 8'h00;
    localparam logic [DATA_W-1:0] BASE_RST = 8'h00;
    localparam logic [DATA_W-1:0] XCNT_RST = 8'h80;
    localparam logic [NUM_EP-1:0] IRQ_RST = 3'h0;

    // ------------------------------------------------------------
    // answer to a host IN request
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RESP_DATA = 2'b00,
        RESP_NAK = 2'b01,
        RESP_STALL = 2'b10
    } resp_kind_t;

endpackage
